// ===== core/dsg_params.svh
// dsg_params.svh: offsets, field positions, reset values and counts for dsg
`ifndef DSG_PARAMS_SVH
`define DSG_PARAMS_SVH

`define DSG_APB_AW 12
`define DSG_OFS_CFG 12'h000
`define DSG_OFS_TYPE 12'h004
`define DSG_OFS_STAT 12'h008

// config register fields
`define DSG_CFG_ESDI_LSB 0
`define DSG_CFG_FLOP_LSB 4
`define DSG_CFG_ESDI_RST 4'h0
`define DSG_CFG_FLOP_RST 4'hC

// status register fields
`define DSG_ST_SEL_LSB 0
`define DSG_ST_QUAL 2
`define DSG_ST_SERIAL 3
`define DSG_ST_FLOP 4

// type register field
`define DSG_TY_BIT 0

// positions inside the synchronised input vector
`define DSG_SY_W 29
`define DSG_SY_PICK 0
`define DSG_SY_QUAL 2
`define DSG_SY_RG 3
`define DSG_SY_CWD 4
`define DSG_SY_RD 5
`define DSG_SY_RC 9
`define DSG_SY_CC 13
`define DSG_SY_RDY 17
`define DSG_SY_SC 21
`define DSG_SY_MF 25

// separator clock: 40 MHz -> 20 MHz tick -> 5 MHz (/4) or 4 MHz (/5)
`define DSG_DIV5_LAST 2'h3
`define DSG_DIV5_HI 2'h2
`define DSG_DIV4_LAST 3'h4
`define DSG_DIV4_HI 3'h2

`endif

// ===== core/dsg_pkg.sv
// dsg_pkg.sv: shared types of the drive select glue
package dsg_pkg;
  typedef logic [1:0] dsg_drive_idx_t;
  typedef logic [3:0] dsg_drive_vec_t;
endpackage : dsg_pkg

// ===== core/dsg_glue.sv
// dsg_glue.sv: drive select glue between a disk controller and four drives
//
// Chosen here: the register addresses and register access over APB.
`timescale 1ns/100ps
`include "dsg_params.svh"

// Contract
// - qualify static selects with select enable
// - decode two bits into four selects
// - force ready when floppy drive selected
// - force seek complete for selected floppy
// - mux esdi signals by select bits
// - present esdi reference clock inverted
// - jumper picks read gate or select four
// - selected drive jumper gives drive type
// - step drive: enable low, muxes released
// - esdi drive: enable high, drive signals pass
// - switch coded data, mark, clock, complete
// - invert drive read data before mux
// - type strobe drives selected jumper out
// - software selects drive before reading type
// - separator clock 4 or 5 MHz
// - three-interface case: drive three is floppy
// - separator clock phases above minimum
// - rate switches at once on reselection
module dsg_glue (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [`DSG_APB_AW-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic drive_pick_bit0_i,
  input wire logic drive_pick_bit1_i,
  input wire logic pick_qualifier_i,
  input wire logic read_gate_i,
  input wire logic coded_write_data_i,
  input wire logic [3:0] drive_read_data_i,
  input wire logic [3:0] read_reference_clock_i,
  input wire logic [3:0] command_complete_i,
  input wire logic [3:0] drive_ready_i,
  input wire logic [3:0] drive_seek_complete_i,
  input wire logic [3:0] mark_found_i,
  output logic [3:0] drive_select_o,
  output logic serial_drive_enable_o,
  output logic drive_ready_in_o,
  output logic seek_complete_o,
  output logic line4_o,
  output logic reference_clock_o,
  output logic reference_clock_oe_n_o,
  output logic command_complete_o,
  output logic command_complete_oe_n_o,
  output logic coded_read_data_o,
  output logic coded_read_data_oe_n_o,
  output logic mark_found_o,
  output logic mark_found_oe_n_o,
  output logic coded_write_data_o,
  output logic coded_write_data_oe_n_o,
  output logic drive_type_o,
  output logic drive_type_oe_n_o,
  output logic sep_clk_o
);

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  // a change counts once stages two and three agree
  logic [`DSG_SY_W-1:0] raw;
  logic [`DSG_SY_W-1:0] s1_r;
  logic [`DSG_SY_W-1:0] s2_r;
  logic [`DSG_SY_W-1:0] s3_r;
  logic [`DSG_SY_W-1:0] q_r;

  assign raw = {mark_found_i, drive_seek_complete_i, drive_ready_i,
                command_complete_i, read_reference_clock_i,
                drive_read_data_i, coded_write_data_i, read_gate_i,
                pick_qualifier_i, drive_pick_bit1_i, drive_pick_bit0_i};

  genvar gi;
  generate
    for (gi = 0; gi < `DSG_SY_W; gi++)
    begin : g_sync
      always_ff @(posedge clk_i or negedge nrst_i)
      begin
        if (!nrst_i)
        begin
          s1_r[gi] <= 1'b0;
          s2_r[gi] <= 1'b0;
          s3_r[gi] <= 1'b0;
          q_r[gi] <= 1'b0;
        end
        else
        begin
          s1_r[gi] <= raw[gi];
          s2_r[gi] <= s1_r[gi];
          s3_r[gi] <= s2_r[gi];
          if (s2_r[gi] == s3_r[gi])
            q_r[gi] <= s3_r[gi];
        end
      end
    end
  endgenerate

  dsg_pkg::dsg_drive_idx_t sel;
  logic qual;
  assign sel = q_r[`DSG_SY_PICK +: 2];
  assign qual = q_r[`DSG_SY_QUAL];

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  dsg_pkg::dsg_drive_vec_t esdi_jmp_r;
  dsg_pkg::dsg_drive_vec_t floppy_map_r;
  logic is_esdi;
  logic is_floppy;

  assign is_esdi = esdi_jmp_r[sel];
  // only step-pulse positions may be floppies
  assign is_floppy = floppy_map_r[sel] & ~is_esdi;

  // ----------------------------------------------------------------
  // apb slave
  // ----------------------------------------------------------------
  // no wait state: pready rises in the first access cycle
  logic setup;
  logic access;
  logic hit_cfg;
  logic hit_type;
  logic hit_stat;
  assign setup = psel_i & ~penable_i;
  assign access = psel_i & penable_i & pready_o;
  assign hit_cfg = (paddr_i == `DSG_OFS_CFG);
  assign hit_type = (paddr_i == `DSG_OFS_TYPE);
  assign hit_stat = (paddr_i == `DSG_OFS_STAT);

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= 32'h0000_0000;
    end
    else
    begin
      pready_o <= setup;
      pslverr_o <= setup & ~(hit_cfg | hit_type | hit_stat);
      prdata_o <= 32'h0000_0000;
      if (setup & ~pwrite_i)
      begin
        if (hit_cfg)
        begin
          prdata_o[`DSG_CFG_ESDI_LSB +: 4] <= esdi_jmp_r;
          prdata_o[`DSG_CFG_FLOP_LSB +: 4] <= floppy_map_r;
        end
        if (hit_type)
          prdata_o[`DSG_TY_BIT] <= is_esdi;
        if (hit_stat)
        begin
          prdata_o[`DSG_ST_SEL_LSB +: 2] <= sel;
          prdata_o[`DSG_ST_QUAL] <= qual;
          prdata_o[`DSG_ST_SERIAL] <= serial_drive_enable_o;
          prdata_o[`DSG_ST_FLOP] <= is_floppy;
        end
      end
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      esdi_jmp_r <= `DSG_CFG_ESDI_RST;
      floppy_map_r <= `DSG_CFG_FLOP_RST;
    end
    else if (access & pwrite_i & hit_cfg)
    begin
      esdi_jmp_r <= pwdata_i[`DSG_CFG_ESDI_LSB +: 4];
      floppy_map_r <= pwdata_i[`DSG_CFG_FLOP_LSB +: 4];
    end
  end

  // the type pin is enabled only in the access cycle of a type port read
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      drive_type_o <= 1'b0;
      drive_type_oe_n_o <= 1'b1;
    end
    else
    begin
      drive_type_o <= is_esdi;
      drive_type_oe_n_o <= ~(setup & ~pwrite_i & hit_type);
    end
  end

  // ----------------------------------------------------------------
  // select decode and drive routing
  // ----------------------------------------------------------------
  // the controller reuses its shared pins per interface, so only
  // the read gate position needs routing here
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      drive_select_o <= 4'h0;
      serial_drive_enable_o <= 1'b0;
      drive_ready_in_o <= 1'b0;
      seek_complete_o <= 1'b0;
      line4_o <= 1'b0;
    end
    else
    begin
      drive_select_o <= {4{qual}} & (4'h1 << sel);
      serial_drive_enable_o <= is_esdi;
      drive_ready_in_o <= is_floppy | q_r[`DSG_SY_RDY + sel];
      seek_complete_o <= is_floppy | q_r[`DSG_SY_SC + sel];
      line4_o <= is_esdi ? q_r[`DSG_SY_RG]
                         : (qual & (&sel));
    end
  end

  // step-pulse drives leave these lines to the data separator
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      reference_clock_o <= 1'b0;
      command_complete_o <= 1'b0;
      coded_read_data_o <= 1'b0;
      mark_found_o <= 1'b0;
      coded_write_data_o <= 1'b0;
      reference_clock_oe_n_o <= 1'b1;
      command_complete_oe_n_o <= 1'b1;
      coded_read_data_oe_n_o <= 1'b1;
      mark_found_oe_n_o <= 1'b1;
      coded_write_data_oe_n_o <= 1'b1;
    end
    else
    begin
      reference_clock_o <= ~q_r[`DSG_SY_RC + sel];
      command_complete_o <= q_r[`DSG_SY_CC + sel];
      coded_read_data_o <= ~q_r[`DSG_SY_RD + sel];
      mark_found_o <= q_r[`DSG_SY_MF + sel];
      coded_write_data_o <= q_r[`DSG_SY_CWD];
      reference_clock_oe_n_o <= ~is_esdi;
      command_complete_oe_n_o <= ~is_esdi;
      coded_read_data_oe_n_o <= ~is_esdi;
      mark_found_oe_n_o <= ~is_esdi;
      coded_write_data_oe_n_o <= ~is_esdi;
    end
  end

  // ----------------------------------------------------------------
  // separator clock divider
  // ----------------------------------------------------------------
  // both rates always run, so a reselection switches at once and
  // may shorten one phase; the separator re-locks within 1 ms
  logic tick20_r;
  logic [1:0] cnt5_r;
  logic [2:0] cnt4_r;
  logic clk5_r;
  logic clk4_r;

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      tick20_r <= 1'b0;
    else
      tick20_r <= ~tick20_r;
  end

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      cnt5_r <= 2'h0;
      cnt4_r <= 3'h0;
      clk5_r <= 1'b0;
      clk4_r <= 1'b0;
    end
    else if (tick20_r)
    begin
      cnt5_r <= (cnt5_r == `DSG_DIV5_LAST) ? 2'h0 : cnt5_r + 2'h1;
      cnt4_r <= (cnt4_r == `DSG_DIV4_LAST) ? 3'h0 : cnt4_r + 3'h1;
      clk5_r <= (cnt5_r < `DSG_DIV5_HI);
      // 2 high ticks, 3 low ticks: not 50 %, yet each phase >= 100 ns
      clk4_r <= (cnt4_r < `DSG_DIV4_HI);
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      sep_clk_o <= 1'b0;
    else
      sep_clk_o <= is_floppy ? clk4_r : clk5_r;
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_select_decode: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    !qual |=> drive_select_o == 4'h0)
    else $error("drive select active without qualifier");

  a_select_onehot: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    qual |=> drive_select_o == (4'h1 << $past(sel)))
    else $error("drive select does not match pick bits");

  a_ready_force: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    is_floppy |=> drive_ready_in_o && seek_complete_o)
    else $error("floppy selection did not force ready");

  a_serial_enable: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    nrst_i |=> serial_drive_enable_o == $past(esdi_jmp_r[sel])
             && reference_clock_oe_n_o == !serial_drive_enable_o)
    else $error("serial enable or mux release wrong");

  a_reference_clock_invert: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    nrst_i |=> reference_clock_o == !$past(q_r[`DSG_SY_RC + sel]))
    else $error("reference clock not inverted");

  a_read_invert: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    nrst_i |=> coded_read_data_o == !$past(q_r[`DSG_SY_RD + sel]))
    else $error("read data not inverted");

  a_line4_route: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    !is_esdi && qual && sel == 2'h3 |=> line4_o)
    else $error("fourth select not routed for step drive");

  a_type_port: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    setup && !pwrite_i && hit_type
      |=> !drive_type_oe_n_o && prdata_o[`DSG_TY_BIT] == drive_type_o)
    else $error("drive type port wrong");

  a_clk5_phase: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    $rose(clk5_r) |-> clk5_r [*4] ##1 !clk5_r [*4])
    else $error("5 MHz phase too short");

  a_clk4_phase: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    $fell(clk4_r) |-> !clk4_r [*6] ##1 clk4_r [*4])
    else $error("4 MHz phases wrong");

  a_rate_pick: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    nrst_i |=> sep_clk_o == ($past(is_floppy) ? $past(clk4_r)
                                            : $past(clk5_r)))
    else $error("separator rate not chosen by drive");

  a_line4_gate: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    nrst_i && is_esdi |=> line4_o == $past(q_r[`DSG_SY_RG]))
    else $error("read gate not routed for serial drive");

  a_status_mux: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    nrst_i |=> command_complete_o == $past(q_r[`DSG_SY_CC + sel])
               && mark_found_o == $past(q_r[`DSG_SY_MF + sel]))
    else $error("command complete or mark found misrouted");

  a_type_idle: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    !(setup && !pwrite_i && hit_type) |=> drive_type_oe_n_o)
    else $error("drive type pin driven outside type read");

endmodule : dsg_glue

// ===== test/dsg_drive_model.sv
// dsg_drive_model.sv: disk controller and four drives facing the glue
`timescale 1ns/100ps
module dsg_drive_model (
  input wire logic clk_i,
  input wire logic [1:0] sel_i,
  input wire logic qual_i,
  input wire logic [3:0] pat_i,
  output wire logic drive_pick_bit0_o,
  output wire logic drive_pick_bit1_o,
  output wire logic pick_qualifier_o,
  output wire logic read_gate_o,
  output wire logic coded_write_data_o,
  output wire logic [3:0] drive_read_data_o,
  output wire logic [3:0] read_reference_clock_o,
  output wire logic [3:0] command_complete_o,
  output wire logic [3:0] drive_ready_o,
  output wire logic [3:0] drive_seek_complete_o,
  output wire logic [3:0] mark_found_o
);
  // ----------------------------------------
  // pins, all moved just after a clock edge
  // ----------------------------------------
  logic [28:0] pin_r = '0;

  // select bits stay static; qualifier travels on its own line
  // the shared line means read gate while the controller runs serial drives
  // reference clock and mark found lines get their own rotation so a wrong mux index shows up
  always @(posedge clk_i)
  begin
    pin_r <= {sel_i, qual_i, pat_i[1], pat_i[3], pat_i,
      {pat_i[0], pat_i[3:1]}, ~pat_i, pat_i, ~pat_i,
      {pat_i[2:0], pat_i[3]}};
  end

  assign {drive_pick_bit1_o, drive_pick_bit0_o, pick_qualifier_o,
    read_gate_o, coded_write_data_o, drive_read_data_o,
    read_reference_clock_o, command_complete_o, drive_ready_o,
    drive_seek_complete_o, mark_found_o} = pin_r;
endmodule : dsg_drive_model

// ===== test/dsg_glue_tb.sv
// dsg_glue_tb.sv: self-checking bench for the drive select glue
`timescale 1ns/100ps
`include "dsg_params.svh"
module dsg_glue_tb;
  logic clk_i, nrst_i, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [1:0] sel;
  logic qual, b0, b1, qn, rgn, wdn, ser, rdy, sc, l4, ty, ty_oe_n, tyc, tyoe;
  logic sclk;
  logic [3:0] pat, m_rd, m_rc, m_cc, m_rdy, m_sc, m_mf, dsel;
  logic [4:0] dv, oen;
  logic [7:0] cfg_tab [3] = '{8'hC0, 8'h85, 8'hCA};
  int error_cnt = 0;
  int n_checks = 0;
  int cyc = 0;

  dsg_drive_model u_dsg_drive_model (.clk_i(clk_i), .sel_i(sel),
    .qual_i(qual), .pat_i(pat), .drive_pick_bit0_o(b0),
    .drive_pick_bit1_o(b1), .pick_qualifier_o(qn), .read_gate_o(rgn),
    .coded_write_data_o(wdn), .drive_read_data_o(m_rd),
    .read_reference_clock_o(m_rc), .command_complete_o(m_cc),
    .drive_ready_o(m_rdy), .drive_seek_complete_o(m_sc),
    .mark_found_o(m_mf));

  dsg_glue u_dsg_glue (.clk_i(clk_i), .nrst_i(nrst_i), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .drive_pick_bit0_i(b0), .drive_pick_bit1_i(b1),
    .pick_qualifier_i(qn), .read_gate_i(rgn), .coded_write_data_i(wdn),
    .drive_read_data_i(m_rd), .read_reference_clock_i(m_rc),
    .command_complete_i(m_cc), .drive_ready_i(m_rdy),
    .drive_seek_complete_i(m_sc), .mark_found_i(m_mf),
    .drive_select_o(dsel), .serial_drive_enable_o(ser),
    .drive_ready_in_o(rdy), .seek_complete_o(sc), .line4_o(l4),
    .reference_clock_o(dv[4]), .reference_clock_oe_n_o(oen[4]),
    .command_complete_o(dv[3]), .command_complete_oe_n_o(oen[3]),
    .coded_read_data_o(dv[2]), .coded_read_data_oe_n_o(oen[2]),
    .mark_found_o(dv[1]), .mark_found_oe_n_o(oen[1]),
    .coded_write_data_o(dv[0]), .coded_write_data_oe_n_o(oen[0]),
    .drive_type_o(ty), .drive_type_oe_n_o(ty_oe_n), .sep_clk_o(sclk));

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task wrap_up;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : wrap_up

  task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk

  // the type pins only drive in the access cycle, so grab them with pready
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    @(posedge clk_i);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk_i);
    penable <= 1'b1;
    do @(posedge clk_i); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    tyc = ty;
    tyoe = ty_oe_n;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task check_pins(input logic [7:0] cfg);
    logic e, f;
    int n, k;
    logic p;
    e = cfg[sel];
    f = cfg[4 + sel] & ~e;
    chk(32'({dsel, ser, oen}), 32'({qual ? 4'b1 << sel : 4'h0, e,
      {5{~e}}}), "select");
    chk(32'(l4), 32'(e ? pat[1] : qual & (sel == 2'd3)), "line4");
    if (e)
      chk(32'(dv), 32'({~pat[(sel + 1) % 4], ~pat[sel], ~pat[sel],
        pat[(sel + 3) % 4], pat[3]}), "esdi");
    apb(1'b0, `DSG_OFS_TYPE, 32'h0);
    chk(rd, 32'(e), "type");
    chk(32'({tyoe, tyc}), 32'({1'b0, e}), "type pin");
    apb(1'b0, `DSG_OFS_STAT, 32'h0);
    chk(rd, 32'({f, e, qual, sel}), "stat");
    if (qual)
    begin
      chk(32'({rdy, sc}), 32'({f | pat[sel], f | ~pat[sel]}), "rdy");
      n = 0;
      k = 0;
      p = 1'b1;
      while (k < 2)
      begin
        @(posedge clk_i);
        if (p === 1'b0 && sclk === 1'b1)
          k++;
        if (k == 1)
          n++;
        p = sclk;
      end
      chk(32'(n), f ? 32'd10 : 32'd8, "sep period");
    end
  endtask : check_pins

  // ----------------------------------------
  // clock, reset, sequence and timeout
  // ----------------------------------------
  initial
  begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  always @(posedge clk_i)
  begin
    cyc++;
    if (cyc == 10000)
    begin
      error_cnt++;
      wrap_up;
    end
  end

  initial
  begin
    nrst_i = 1'b0;
    {psel, penable, pwrite, paddr, pwdata, sel, qual, pat} = '0;
    repeat (8) @(posedge clk_i);
    chk(32'({dsel, ser, oen, ty_oe_n, sclk}), 32'h0000_007E, "reset");
    nrst_i <= 1'b1;
    apb(1'b0, `DSG_OFS_CFG, 32'h0);
    chk(rd, 32'h0000_00C0, "cfg reset");
    apb(1'b0, 12'h00C, 32'h0);
    chk({rd[30:0], err}, 32'h0000_0001, "unmapped");
    for (int c = 0; c < 3; c++)
    begin
      apb(1'b1, `DSG_OFS_CFG, {24'hFF_FFFF, cfg_tab[c]});
      apb(1'b0, `DSG_OFS_CFG, 32'h0);
      chk(rd, 32'(cfg_tab[c]), "cfg readback");
      for (int i = 0; i < 16; i++)
      begin
        sel <= 2'(i);
        qual <= i[2];
        pat <= i[3] ? 4'h9 : 4'h6;
        repeat (9) @(posedge clk_i);
        check_pins(cfg_tab[c]);
      end
    end
    wrap_up;
  end
endmodule : dsg_glue_tb
